// File: logic/gip_pkg.sv
/*
  shared constants and carrier types for the gyro interrupt-pin and self-test register bank.
  assumes a 100 MHz system clock and a gyro core that reports data-ready and self-test events.
*/
`default_nettype none
package gip_pkg;
  // register addresses, seven-bit as carried on the serial links
  localparam logic [6:0] ADDR_INT_CTRL = 7'h15;
  localparam logic [6:0] ADDR_PIN_CONF = 7'h16;
  localparam logic [6:0] ADDR_ROUTE = 7'h18;
  localparam logic [6:0] ADDR_SELF_TEST = 7'h3c;
  // pin configuration fields
  localparam int CONF_A_LVL = 0;
  localparam int CONF_A_OD = 1;
  localparam int CONF_B_LVL = 2;
  localparam int CONF_B_OD = 3;
  localparam logic [3:0] CONF_RESET = 4'h0;
  // data-ready routing and enable codes
  localparam logic [7:0] ROUTE_NONE = 8'h00;
  localparam logic [7:0] ROUTE_A = 8'h01;
  localparam logic [7:0] ROUTE_B = 8'h80;
  localparam logic [7:0] ROUTE_BOTH = 8'h81;
  localparam logic [7:0] INT_CTRL_OFF = 8'h00;
  localparam logic [7:0] INT_CTRL_ON = 8'h80;
  // self-test fields
  localparam int ST_TRIG = 0;
  localparam int ST_RDY = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RATE_OK = 4;
  // upper six bits of the two-wire slave address; the lowest bit comes from the data-out pin
  localparam logic [5:0] I2C_ADDR_HIGH = 6'h34;
  // timing
  localparam int CLK_NS = 10;
  localparam int WAIT_NORMAL_NS = 2000;
  localparam int WAIT_SUSPEND_NS = 1000000;
  localparam int WAIT_NORMAL_CYC = (WAIT_NORMAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_PULSE_NS = 100;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] INT_PULSE_LEN = 4'(INT_PULSE_CYC);

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } gip_wr_t;

  typedef struct packed {
    logic open_drain;
    logic active_high;
  } gip_pin_t;
endpackage
`default_nettype wire

// File: logic/gip_regs.sv
/*
  gyro-side register bank: interrupt pin drivers, data-ready routing, self-test control,
  reached by a four-wire serial slave (clocked by the serial clock pin) or a two-wire slave.
  assumes the core's data-ready and self-test signals are synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module gip_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic protocol_select_pin,
  input wire logic serial_clk,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe,
  input wire logic gyro_chip_select_n,
  input wire logic gyro_serial_out_i,
  output logic gyro_serial_out_o,
  output logic gyro_serial_out_oe,
  input wire logic data_ready,
  input wire logic bist_done,
  input wire logic bist_failed,
  input wire logic rate_ok_in,
  output logic bist_start,
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe
);
  logic [7:0] int_ctrl;
  logic [3:0] pin_conf;
  logic [7:0] route;
  logic st_rdy, st_fail, st_rate_ok;
  logic [2:0] ps_sync, csn_sync, scl_sync, sda_sync, adr_sync;
  logic strap_done, i2c_mode, addr_lsb;
  logic [31:0] shadow;

  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [31:0] r);
    unique case (a)
      gip_pkg::ADDR_INT_CTRL: rd_mux = r[31:24];
      gip_pkg::ADDR_PIN_CONF: rd_mux = r[23:16];
      gip_pkg::ADDR_ROUTE: rd_mux = r[15:8];
      gip_pkg::ADDR_SELF_TEST: rd_mux = r[7:0];
      default: rd_mux = 8'h00;
    endcase
  endfunction

  logic [31:0] live;
  assign live = {int_ctrl, 4'h0, pin_conf, route,
                 3'h0, st_rate_ok, 1'b0, st_fail, st_rdy, 1'b0};

  // pin inputs: two stages, third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    ps_sync <= {ps_sync[1:0], protocol_select_pin};
    csn_sync <= {csn_sync[1:0], gyro_chip_select_n};
    scl_sync <= {scl_sync[1:0], serial_clk};
    sda_sync <= {sda_sync[1:0], serial_data_i};
    adr_sync <= {adr_sync[1:0], gyro_serial_out_i};
  end

  // straps caught once after reset release; a moving strap mid-transfer would corrupt framing
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_done <= 1'b0;
      i2c_mode <= 1'b0;
      addr_lsb <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      i2c_mode <= ps_sync[1];
      addr_lsb <= adr_sync[1];
    end
  end

  // four-wire link, serial clock domain; chip select high clears the frame
  logic [4:0] spi_cnt;
  logic [6:0] spi_shift;
  logic spi_rw;
  logic [6:0] spi_addr;
  gip_pkg::gip_wr_t spi_word;
  logic spi_tgl;
  logic spi_sdo, spi_drive;
  logic [7:0] spi_byte;

  always_ff @(posedge serial_clk or posedge gyro_chip_select_n) begin
    if (gyro_chip_select_n) begin
      spi_cnt <= 5'h00;
      spi_shift <= 7'h00;
    end else begin
      spi_shift <= {spi_shift[5:0], serial_data_i};
      spi_cnt <= (spi_cnt == 5'h0f) ? 5'h08 : spi_cnt + 5'h01;
    end
  end

  always_ff @(posedge serial_clk or negedge nrst) begin
    if (!nrst) begin
      spi_rw <= 1'b0;
      spi_addr <= 7'h00;
      spi_word <= '0;
      spi_tgl <= 1'b0;
    end else if (!gyro_chip_select_n) begin
      if (spi_cnt == 5'h07) begin
        spi_rw <= spi_shift[6];
        spi_addr <= spi_shift[5:0] == 6'h00 ? {spi_shift[5:0], serial_data_i} : {spi_shift[5:0], serial_data_i};
      end else if (spi_cnt == 5'h0f) begin
        // burst reads walk the address; the write word stays put until the next byte ends
        spi_addr <= spi_addr + 7'h01;
        if (!spi_rw && !i2c_mode) begin
          spi_word <= '{addr: spi_addr, data: {spi_shift, serial_data_i}};
          spi_tgl <= ~spi_tgl;
        end
      end
    end
  end

  // shadow is frozen while chip select is active, so the link reads a stable word
  assign spi_byte = rd_mux(spi_addr, shadow);
  always_ff @(negedge serial_clk or posedge gyro_chip_select_n) begin
    if (gyro_chip_select_n) begin
      spi_sdo <= 1'b0;
      spi_drive <= 1'b0;
    end else begin
      spi_drive <= spi_rw && spi_cnt[3] && !i2c_mode;
      spi_sdo <= spi_byte[3'(~spi_cnt[2:0])];
    end
  end
  assign gyro_serial_out_o = spi_sdo;
  assign gyro_serial_out_oe = spi_drive;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shadow <= '0;
    end else if (csn_sync[1]) begin
      shadow <= live;
    end
  end

  logic [2:0] tgl_sync;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], spi_tgl};
    end
  end

  // two-wire slave, oversampled on sys_clk
  typedef enum {I_IDLE, I_ADDR, I_ACK, I_REG, I_WDATA, I_RDATA, I_RACK} gip_i2c_t;
  gip_i2c_t i_state, i_after;
  logic [3:0] i_cnt;
  logic [7:0] i_shift, i_tx;
  logic [6:0] i_ptr;
  logic i_rw, i_sda_low, i_wr;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_sync[1] && !scl_sync[2];
  assign scl_fall = !scl_sync[1] && scl_sync[2];
  assign start_c = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
  assign stop_c = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];

  always_ff @(posedge sys_clk) begin
    if (!nrst || !i2c_mode) begin
      i_state <= I_IDLE;
      i_after <= I_IDLE;
      i_cnt <= 4'h0;
      i_shift <= 8'h00;
      i_tx <= 8'h00;
      i_ptr <= 7'h00;
      i_rw <= 1'b0;
      i_sda_low <= 1'b0;
      i_wr <= 1'b0;
    end else begin
      i_wr <= 1'b0;
      // on a write, the pointer steps only after the write port has used it
      if (i_wr) i_ptr <= i_ptr + 7'h01;
      if (start_c) begin
        i_state <= I_ADDR;
        i_cnt <= 4'h0;
        i_sda_low <= 1'b0;
      end else if (stop_c) begin
        i_state <= I_IDLE;
        i_sda_low <= 1'b0;
      end else if (scl_rise && i_state inside {I_ADDR, I_REG, I_WDATA}) begin
        i_shift <= {i_shift[6:0], sda_sync[1]};
        i_cnt <= i_cnt + 4'h1;
      end else if (scl_rise && i_state == I_RACK) begin
        // a master ack keeps the state until the falling edge loads the next byte
        if (sda_sync[1]) i_state <= I_IDLE;
      end else if (scl_fall) begin
        unique case (i_state)
          I_ADDR:
            if (i_cnt == 4'h8) begin
              if (i_shift[7:1] == {gip_pkg::I2C_ADDR_HIGH, addr_lsb}) begin
                i_rw <= i_shift[0];
                i_sda_low <= 1'b1;
                i_state <= I_ACK;
                i_after <= i_shift[0] ? I_RDATA : I_REG;
                i_tx <= rd_mux(i_ptr, live);
              end else begin
                i_state <= I_IDLE;
              end
            end
          I_REG, I_WDATA:
            if (i_cnt == 4'h8) begin
              i_sda_low <= 1'b1;
              i_state <= I_ACK;
              i_after <= I_WDATA;
              if (i_state == I_REG) begin
                i_ptr <= i_shift[6:0];
              end else begin
                i_wr <= 1'b1;
              end
            end
          I_ACK: begin
            i_cnt <= 4'h0;
            i_state <= i_after;
            i_sda_low <= (i_after == I_RDATA) && !i_tx[7];
          end
          I_RDATA: begin
            i_cnt <= i_cnt + 4'h1;
            if (i_cnt == 4'h7) begin
              i_sda_low <= 1'b0;
              i_state <= I_RACK;
              i_ptr <= i_ptr + 7'h01;
            end else begin
              i_sda_low <= !i_tx[3'(4'h6 - i_cnt)];
            end
          end
          I_RACK: begin
            i_cnt <= 4'h0;
            i_tx <= rd_mux(i_ptr, live);
            i_state <= I_RDATA;
            i_sda_low <= (rd_mux(i_ptr, live) & 8'h80) == 8'h00;
          end
          default: i_state <= I_IDLE;
        endcase
      end
    end
  end
  assign serial_data_o = 1'b0;
  assign serial_data_oe = i_sda_low;

  // one write port for both links
  gip_pkg::gip_wr_t wr;
  logic wr_en;
  always_comb begin
    wr_en = 1'b0;
    wr = spi_word;
    if (i2c_mode) begin
      wr_en = i_wr;
      wr = '{addr: i_ptr, data: i_shift};
    end else if (tgl_sync[2] != tgl_sync[1]) begin
      wr_en = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      int_ctrl <= gip_pkg::INT_CTRL_OFF;
      pin_conf <= gip_pkg::CONF_RESET;
      route <= gip_pkg::ROUTE_NONE;
    end else if (wr_en) begin
      if (wr.addr == gip_pkg::ADDR_INT_CTRL) int_ctrl <= wr.data;
      if (wr.addr == gip_pkg::ADDR_PIN_CONF) pin_conf <= wr.data[3:0];
      if (wr.addr == gip_pkg::ADDR_ROUTE) route <= wr.data;
    end
  end

  // self-test: a new trigger clears the ready flag, a finish in the same cycle wins
  logic trig;
  assign trig = wr_en && wr.addr == gip_pkg::ADDR_SELF_TEST && wr.data[gip_pkg::ST_TRIG];
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bist_start <= 1'b0;
      st_rdy <= 1'b0;
      st_fail <= 1'b0;
      st_rate_ok <= 1'b0;
    end else begin
      bist_start <= trig;
      st_rate_ok <= rate_ok_in;
      if (bist_done) begin
        st_rdy <= 1'b1;
        st_fail <= bist_failed;
      end else if (trig) begin
        st_rdy <= 1'b0;
      end
    end
  end

  // data-ready stretched so a slow host edge detector still sees it
  logic [3:0] drdy_cnt;
  logic drdy_act;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drdy_cnt <= 4'h0;
    end else if (data_ready && int_ctrl == gip_pkg::INT_CTRL_ON) begin
      drdy_cnt <= gip_pkg::INT_PULSE_LEN;
    end else if (drdy_cnt != 4'h0) begin
      drdy_cnt <= drdy_cnt - 4'h1;
    end
  end
  assign drdy_act = drdy_cnt != 4'h0;

  logic act_a, act_b;
  gip_pkg::gip_pin_t cfg_a, cfg_b;
  assign act_a = drdy_act && (route == gip_pkg::ROUTE_A || route == gip_pkg::ROUTE_BOTH);
  assign act_b = drdy_act && (route == gip_pkg::ROUTE_B || route == gip_pkg::ROUTE_BOTH);
  assign cfg_a = '{open_drain: pin_conf[gip_pkg::CONF_A_OD], active_high: pin_conf[gip_pkg::CONF_A_LVL]};
  assign cfg_b = '{open_drain: pin_conf[gip_pkg::CONF_B_OD], active_high: pin_conf[gip_pkg::CONF_B_LVL]};
  assign irq_pin_a_o = act_a ? cfg_a.active_high : ~cfg_a.active_high;
  assign irq_pin_a_oe = !cfg_a.open_drain || act_a;
  assign irq_pin_b_o = act_b ? cfg_b.active_high : ~cfg_b.active_high;
  assign irq_pin_b_oe = !cfg_b.open_drain || act_b;

  property p_pin_a_level;
    @(posedge sys_clk) disable iff (!nrst) act_a && irq_pin_a_oe |-> irq_pin_a_o == pin_conf[gip_pkg::CONF_A_LVL];
  endproperty
  a_pin_a_level: assert property (p_pin_a_level) else $error("pin a active level wrong");
  property p_pin_a_od;
    @(posedge sys_clk) disable iff (!nrst) pin_conf[gip_pkg::CONF_A_OD] && !drdy_act |-> !irq_pin_a_oe;
  endproperty
  a_pin_a_od: assert property (p_pin_a_od) else $error("pin a driven while open-drain idle");
  property p_pin_b_level;
    @(posedge sys_clk) disable iff (!nrst) !act_b && !pin_conf[gip_pkg::CONF_B_OD] |-> irq_pin_b_o != pin_conf[gip_pkg::CONF_B_LVL];
  endproperty
  a_pin_b_level: assert property (p_pin_b_level) else $error("pin b idle level wrong");
  property p_pin_b_od;
    @(posedge sys_clk) disable iff (!nrst) pin_conf[gip_pkg::CONF_B_OD] |-> irq_pin_b_oe == act_b;
  endproperty
  a_pin_b_od: assert property (p_pin_b_od) else $error("pin b open-drain enable wrong");
  property p_route_none;
    @(posedge sys_clk) disable iff (!nrst) route == gip_pkg::ROUTE_NONE |-> !act_a && !act_b;
  endproperty
  a_route_none: assert property (p_route_none) else $error("unrouted data-ready reached a pin");
  property p_route_a;
    @(posedge sys_clk) disable iff (!nrst)
      data_ready && int_ctrl == gip_pkg::INT_CTRL_ON && route == gip_pkg::ROUTE_A && !wr_en
      |=> act_a && !act_b [*3];
  endproperty
  a_route_a: assert property (p_route_a) else $error("data-ready not on pin a alone");
  property p_trig;
    @(posedge sys_clk) disable iff (!nrst) trig |=> bist_start ##1 !bist_start || trig;
  endproperty
  a_trig: assert property (p_trig) else $error("self-test start pulse missing");
  property p_rdy;
    @(posedge sys_clk) disable iff (!nrst) bist_done |=> st_rdy && st_fail == $past(bist_failed);
  endproperty
  a_rdy: assert property (p_rdy) else $error("self-test finish not recorded");
  property p_fail_hold;
    @(posedge sys_clk) disable iff (!nrst) !bist_done |=> $stable(st_fail);
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("self-test result moved without a finish");
  property p_rate;
    @(posedge sys_clk) disable iff (!nrst) ##1 1'b1 |-> st_rate_ok == $past(rate_ok_in);
  endproperty
  a_rate: assert property (p_rate) else $error("rate flag does not follow the core");
  property p_ctrl_off;
    @(posedge sys_clk) disable iff (!nrst) int_ctrl != gip_pkg::INT_CTRL_ON && !drdy_act |=> !drdy_act;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) else $error("data-ready raised while disabled");
  property p_i2c_quiet;
    @(posedge sys_clk) disable iff (!nrst) !i2c_mode |-> !serial_data_oe;
  endproperty
  a_i2c_quiet: assert property (p_i2c_quiet) else $error("two-wire drive in four-wire mode");
endmodule // gip_regs
`default_nettype wire

// File: verification/gip_host_model.sv
/*
  host model: four-wire and two-wire serial master that reaches the gyro register bank.
  assumes mode 00 framing and an open-drain data line seen back on sda_seen; clocks run only inside frames.
*/
`timescale 1ns/1ns
`default_nettype none
module gip_host_model (
  output logic serial_clk,
  output logic serial_data_i,
  output logic gyro_chip_select_n,
  input wire logic gyro_serial_out,
  input wire logic sda_seen
);
  localparam int HALF_NS = 24;
  localparam int TW_HALF_NS = 240;
  initial begin
    serial_clk = 1'b0;
    serial_data_i = 1'b1;
    gyro_chip_select_n = 1'b1;
  end
  // one 16-bit frame; sel low keeps chip select high so the device must stay deaf
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, input logic sel, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    gyro_chip_select_n = ~sel;
    for (int i = 15; i >= 0; i--) begin
      serial_data_i = sh[i];
      #HALF_NS serial_clk = 1'b1;
      if (i < 8) rd = {rd[6:0], gyro_serial_out};
      #HALF_NS serial_clk = 1'b0;
    end
    #HALF_NS gyro_chip_select_n = 1'b1;
    // released line shows the inverse, so a stale bit never passes for data
    serial_data_i = ~sh[0];
    if (!hdr[7]) #2000;
    else #100;
  endtask
  // two-wire helpers: data moves only while the clock is low, except in start and stop
  task automatic tw_start();
    serial_data_i = 1'b1;
    #TW_HALF_NS serial_clk = 1'b1;
    #TW_HALF_NS serial_data_i = 1'b0;
    #TW_HALF_NS serial_clk = 1'b0;
  endtask
  task automatic tw_stop();
    serial_data_i = 1'b0;
    #TW_HALF_NS serial_clk = 1'b1;
    #TW_HALF_NS serial_data_i = 1'b1;
    #TW_HALF_NS serial_clk = 1'b0;
  endtask
  // eight data bits then the ack bit; a one releases the line
  task automatic tw_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      serial_data_i = tx[i];
      #TW_HALF_NS serial_clk = 1'b1;
      #TW_HALF_NS rx[i] = sda_seen;
      serial_clk = 1'b0;
    end
  endtask
  task automatic tw_write(input logic [6:0] dev, input logic [6:0] ra, input logic [7:0] wd, output logic [2:0] acks);
    logic [8:0] rx;
    tw_start();
    tw_byte({dev, 1'b0, 1'b1}, rx);
    acks[2] = rx[0];
    tw_byte({1'b0, ra, 1'b1}, rx);
    acks[1] = rx[0];
    tw_byte({wd, 1'b1}, rx);
    acks[0] = rx[0];
    tw_stop();
    #2000;
  endtask
  // pointer set by a write header, then a repeated start and one byte closed by a nack
  task automatic tw_read(input logic [6:0] dev, input logic [6:0] ra, output logic [7:0] rd);
    logic [8:0] rx;
    tw_start();
    tw_byte({dev, 1'b0, 1'b1}, rx);
    tw_byte({1'b0, ra, 1'b1}, rx);
    tw_start();
    tw_byte({dev, 1'b1, 1'b1}, rx);
    tw_byte(9'h1ff, rx);
    rd = rx[8:1];
    tw_stop();
  endtask
endmodule // gip_host_model
`default_nettype wire

// File: verification/gyro_int_pin_and_self_test_tb.sv
/*
  self-checking bench for the gyro interrupt-pin and self-test register bank.
  assumes the four-wire and two-wire host model and a core that pulses data_ready and bist_done.
*/
`timescale 1ns/1ns
`default_nettype none
module gyro_int_pin_and_self_test_tb;
  logic sys_clk, nrst, protocol_select_pin, data_ready, bist_done, bist_failed, rate_ok_in, sdo_fill;
  logic serial_clk, host_sdi, gyro_chip_select_n, serial_data_o, serial_data_oe;
  logic gyro_serial_out_o, gyro_serial_out_oe, bist_start;
  logic irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe, irq_on;
  wire sda_line;
  wire sdo_line;
  int err_count, cmp_count, bist_cnt, n0;
  logic [7:0] r, route;
  logic [2:0] ack;
  logic [3:0] conf;
  logic [7:0] routes [5];
  logic [6:0] addrs [5];
  // sda is open-drain with a pull-up; a released data-out shows a toggling filler,
  // but in two-wire mode the data-out pin is strapped high to fix the address lsb
  assign sda_line = serial_data_oe ? 1'b0 : host_sdi;
  assign sdo_line = gyro_serial_out_oe ? gyro_serial_out_o : (protocol_select_pin ? 1'b1 : sdo_fill);

  gip_regs i_gip_regs (
    .sys_clk(sys_clk), .nrst(nrst), .protocol_select_pin(protocol_select_pin),
    .serial_clk(serial_clk), .serial_data_i(sda_line), .serial_data_o(serial_data_o),
    .serial_data_oe(serial_data_oe), .gyro_chip_select_n(gyro_chip_select_n),
    .gyro_serial_out_i(sdo_line), .gyro_serial_out_o(gyro_serial_out_o),
    .gyro_serial_out_oe(gyro_serial_out_oe), .data_ready(data_ready), .bist_done(bist_done),
    .bist_failed(bist_failed), .rate_ok_in(rate_ok_in), .bist_start(bist_start),
    .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe), .irq_pin_b_o(irq_pin_b_o),
    .irq_pin_b_oe(irq_pin_b_oe)
  );
  gip_host_model i_gip_host_model (
    .serial_clk(serial_clk), .serial_data_i(host_sdi),
    .gyro_chip_select_n(gyro_chip_select_n), .gyro_serial_out(sdo_line),
    .sda_seen(sda_line)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    sdo_fill <= ~sdo_fill;
    if (bist_start === 1'b1) bist_cnt++;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    i_gip_host_model.xfer({1'b0, a}, d, 1'b1, dummy);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_gip_host_model.xfer({1'b1, a}, 8'h00, 1'b1, d);
  endtask
  task automatic do_reset(input logic ps);
    @(negedge sys_clk);
    nrst = 1'b0;
    protocol_select_pin = ps;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
  function automatic logic routed(input logic [7:0] rt, input logic to_b);
    if (to_b) routed = (rt == gip_pkg::ROUTE_B) || (rt == gip_pkg::ROUTE_BOTH);
    else routed = (rt == gip_pkg::ROUTE_A) || (rt == gip_pkg::ROUTE_BOTH);
  endfunction
  task automatic pin_chk(input logic o, input logic oe, input logic lvl, input logic od, input logic act);
    check("pin_enable", {7'h00, oe}, {7'h00, act | ~od});
    if (act | ~od) check("pin_level", {7'h00, o}, {7'h00, act ? lvl : ~lvl});
  endtask
  task automatic pins(input logic act);
    pin_chk(irq_pin_a_o, irq_pin_a_oe, conf[0], conf[1], act & irq_on & routed(route, 1'b0));
    pin_chk(irq_pin_b_o, irq_pin_b_oe, conf[2], conf[3], act & irq_on & routed(route, 1'b1));
  endtask
  task automatic st_done(input logic f);
    @(negedge sys_clk);
    bist_failed = f;
    bist_done = 1'b1;
    @(negedge sys_clk);
    bist_done = 1'b0;
    bist_failed = 1'($urandom);
  endtask

  initial begin
    #600000;
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    protocol_select_pin = 1'b0;
    data_ready = 1'b0;
    bist_done = 1'b0;
    bist_failed = 1'b0;
    rate_ok_in = 1'b0;
    sdo_fill = 1'b0;
    routes = '{gip_pkg::ROUTE_NONE, gip_pkg::ROUTE_A, gip_pkg::ROUTE_B, gip_pkg::ROUTE_BOTH, 8'h42};
    addrs = '{gip_pkg::ADDR_INT_CTRL, gip_pkg::ADDR_PIN_CONF, gip_pkg::ADDR_ROUTE, gip_pkg::ADDR_SELF_TEST, 7'h20};
    void'($urandom(87644));
    do_reset(1'b0);
    foreach (addrs[k]) begin
      rd(addrs[k], r);
      check("reset_value", r, 8'h00);
    end
    wr(7'h20, 8'hff);
    rd(7'h20, r);
    check("unmapped", r, 8'h00);
    // frame with chip select held high must not land
    i_gip_host_model.xfer({1'b0, gip_pkg::ADDR_PIN_CONF}, 8'h0f, 1'b0, r);
    rd(gip_pkg::ADDR_PIN_CONF, r);
    check("deselected_write", r, 8'h00);
    // two-wire strap: four-wire frames are ignored, pin a stays push-pull active low
    do_reset(1'b1);
    wr(gip_pkg::ADDR_PIN_CONF, 8'h0f);
    @(negedge sys_clk);
    check("strap_level", {6'h00, irq_pin_a_o, irq_pin_a_oe}, 8'h03);
    // two-wire: the address with the wrong lsb goes unanswered, the strapped one is acked
    i_gip_host_model.tw_write({gip_pkg::I2C_ADDR_HIGH, 1'b0}, gip_pkg::ADDR_PIN_CONF, 8'h05, ack);
    check("tw_wrong_addr_ack", {5'h00, ack}, 8'h07);
    i_gip_host_model.tw_write({gip_pkg::I2C_ADDR_HIGH, 1'b1}, gip_pkg::ADDR_PIN_CONF, 8'h05, ack);
    check("tw_ack", {5'h00, ack}, 8'h00);
    i_gip_host_model.tw_read({gip_pkg::I2C_ADDR_HIGH, 1'b1}, gip_pkg::ADDR_PIN_CONF, r);
    check("tw_read", r, 8'h05);
    do_reset(1'b0);
    for (int i = 0; i < 20; i++) begin
      conf = (i < 16) ? 4'(i) : 4'($urandom);
      route = (i % 5 == 4) ? 8'($urandom) : routes[i % 5];
      irq_on = (i % 7 != 3);
      wr(gip_pkg::ADDR_PIN_CONF, {4'($urandom), conf});
      wr(gip_pkg::ADDR_ROUTE, route);
      wr(gip_pkg::ADDR_INT_CTRL, irq_on ? gip_pkg::INT_CTRL_ON : gip_pkg::INT_CTRL_OFF);
      rd(gip_pkg::ADDR_PIN_CONF, r);
      check("pin_config", r, {4'h0, conf});
      rd(gip_pkg::ADDR_ROUTE, r);
      check("routing", r, route);
      @(negedge sys_clk);
      pins(1'b0);
      data_ready = 1'b1;
      @(negedge sys_clk);
      data_ready = 1'b0;
      repeat (gip_pkg::INT_PULSE_CYC / 2) @(negedge sys_clk);
      pins(1'b1);
      repeat (gip_pkg::INT_PULSE_CYC + 3) @(negedge sys_clk);
      pins(1'b0);
    end
    @(negedge sys_clk);
    rate_ok_in = 1'b1;
    n0 = bist_cnt;
    wr(gip_pkg::ADDR_SELF_TEST, 8'hfe);
    check("no_start", 8'(bist_cnt - n0), 8'h00);
    wr(gip_pkg::ADDR_SELF_TEST, 8'h01);
    check("start", 8'(bist_cnt - n0), 8'h01);
    rd(gip_pkg::ADDR_SELF_TEST, r);
    check("self_test_busy", r, 8'h10);
    for (int f = 0; f < 2; f++) begin
      st_done(1'(f));
      rd(gip_pkg::ADDR_SELF_TEST, r);
      check("self_test_result", r, 8'h12 | 8'(f << 2));
    end
    wr(gip_pkg::ADDR_SELF_TEST, 8'h01);
    rd(gip_pkg::ADDR_SELF_TEST, r);
    // a new start clears only the finished flag; the old result bit stays
    check("self_test_rerun", r, 8'h14);
    report_and_stop();
  end
endmodule // gyro_int_pin_and_self_test_tb
`default_nettype wire
